// >>> rtl/sspr_top.sv
// Register file and pin routing of the sync serial channel onto port 4 or port A.
`timescale 1ns/10ps
module sspr_top (
    // Clock, reset, enable.
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Register port.
    input wire logic [sspr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sspr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sspr_pkg::DATA_W-1:0] reg_rdata,
    // Serial unit side.
    input wire logic serial_data_out,
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe,
    output logic serial_clock_in,
    output logic serial_data_in,
    // Port 4 pins.
    input wire logic [7:0] port4_pin_in,
    output logic [7:0] port4_pin_out,
    output logic [7:0] port4_pin_oe,
    // Port A pins.
    input wire logic [7:0] porta_pin_in,
    output logic [7:0] porta_pin_out,
    output logic [7:0] porta_pin_oe
);
    import sspr_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] p4_dat_r, p4_dir_r, p4_con0_r, p4_con1_r, p4_sel0_r, p4_sel1_r;
    logic [7:0] pa_dat_r, pa_dir_r, pa_con0_r, pa_con1_r, pa_sel0_r;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction : hit

    always_ff @(posedge core_clk) begin
        if (reset) begin
            p4_dat_r <= REG_RESET;
            p4_dir_r <= REG_RESET;
            p4_con0_r <= REG_RESET;
            p4_con1_r <= REG_RESET;
            p4_sel0_r <= REG_RESET;
            p4_sel1_r <= REG_RESET;
            pa_dat_r <= REG_RESET;
            pa_dir_r <= REG_RESET;
            pa_con0_r <= REG_RESET;
            pa_con1_r <= REG_RESET;
            pa_sel0_r <= REG_RESET;
        end else if (clk_en && reg_wr) begin
            if (hit(reg_addr, P4_DATA_ADDR)) p4_dat_r <= reg_wdata;
            if (hit(reg_addr, P4_DIR_ADDR)) p4_dir_r <= reg_wdata;
            if (hit(reg_addr, P4_CON0_ADDR)) p4_con0_r <= reg_wdata; // see RULE4
            if (hit(reg_addr, P4_CON1_ADDR)) p4_con1_r <= reg_wdata; // see RULE4
            if (hit(reg_addr, P4_SEL0_ADDR)) p4_sel0_r <= reg_wdata & P4_SEL_MASK;
            if (hit(reg_addr, P4_SEL1_ADDR)) p4_sel1_r <= reg_wdata & P4_SEL_MASK;
            if (hit(reg_addr, PA_DATA_ADDR)) pa_dat_r <= reg_wdata;
            if (hit(reg_addr, PA_DIR_ADDR)) pa_dir_r <= reg_wdata;
            if (hit(reg_addr, PA_CON0_ADDR)) pa_con0_r <= reg_wdata; // see RULE10
            if (hit(reg_addr, PA_CON1_ADDR)) pa_con1_r <= reg_wdata; // see RULE10
            if (hit(reg_addr, PA_SEL0_ADDR)) pa_sel0_r <= reg_wdata & PA_SEL_MASK;
        end
    end

    // ****************************************************************
    // Function selection
    // ****************************************************************
    wire [2:0] p4_func = p4_sel0_r[2:0] & ~p4_sel1_r[2:0]; // see RULE1 RULE6
    wire [2:0] pa_func = pa_sel0_r[2:0]; // see RULE7 RULE12
    wire p4_all = &p4_func;
    wire pa_all = &pa_func;

    sspr_port_if p4_if ();
    sspr_port_if pa_if ();

    assign p4_if.dat = p4_dat_r;
    assign p4_if.dir = p4_dir_r;
    assign p4_if.con0 = p4_con0_r;
    assign p4_if.con1 = p4_con1_r;
    assign p4_if.func_en = p4_func;
    assign p4_if.alt_out = {serial_data_out, serial_clock_out, 1'b0};
    assign pa_if.dat = pa_dat_r;
    assign pa_if.dir = pa_dir_r;
    assign pa_if.con0 = pa_con0_r;
    assign pa_if.con1 = pa_con1_r;
    assign pa_if.func_en = pa_func;
    assign pa_if.alt_out = {serial_data_out, serial_clock_out, 1'b0};

    sspr_pad_ctl u_p4 (.port(p4_if));
    sspr_pad_ctl u_pa (.port(pa_if));

    // The serial clock pin drives only while the unit drives it (master).
    wire [7:0] p4_oe_nxt = p4_if.pin_oe & ~{6'h00, ~serial_clock_oe & p4_func[BIT_SCK], 1'b0};
    wire [7:0] pa_oe_nxt = pa_if.pin_oe & ~{6'h00, ~serial_clock_oe & pa_func[BIT_SCK], 1'b0};

    // Inputs back to the unit; port 4 wins when both are routed.
    wire sin_nxt = (p4_func[BIT_SIN] && p4_dir_r[BIT_SIN]) ? port4_pin_in[BIT_SIN] :
                   (pa_func[BIT_SIN] && pa_dir_r[BIT_SIN]) ? porta_pin_in[BIT_SIN] :
                   1'b0; // see RULE3 RULE9
    wire sck_nxt = (p4_func[BIT_SCK] && p4_dir_r[BIT_SCK]) ? port4_pin_in[BIT_SCK] :
                   (pa_func[BIT_SCK] && pa_dir_r[BIT_SCK]) ? porta_pin_in[BIT_SCK] :
                   1'b0; // see RULE3 RULE13

    wire [7:0] rd_mux =
        hit(reg_addr, P4_DATA_ADDR) ? p4_dat_r :
        hit(reg_addr, P4_DIR_ADDR) ? p4_dir_r :
        hit(reg_addr, P4_CON0_ADDR) ? p4_con0_r :
        hit(reg_addr, P4_CON1_ADDR) ? p4_con1_r :
        hit(reg_addr, P4_SEL0_ADDR) ? p4_sel0_r :
        hit(reg_addr, P4_SEL1_ADDR) ? p4_sel1_r :
        hit(reg_addr, PA_DATA_ADDR) ? pa_dat_r :
        hit(reg_addr, PA_DIR_ADDR) ? pa_dir_r :
        hit(reg_addr, PA_CON0_ADDR) ? pa_con0_r :
        hit(reg_addr, PA_CON1_ADDR) ? pa_con1_r :
        hit(reg_addr, PA_SEL0_ADDR) ? pa_sel0_r : 8'h00;

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            port4_pin_out <= 8'h00;
            port4_pin_oe <= 8'h00;
            porta_pin_out <= 8'h00;
            porta_pin_oe <= 8'h00;
            serial_clock_in <= 1'b0;
            serial_data_in <= 1'b0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            port4_pin_out <= p4_if.pin_out;
            port4_pin_oe <= p4_oe_nxt;
            porta_pin_out <= pa_if.pin_out;
            porta_pin_oe <= pa_oe_nxt;
            serial_clock_in <= sck_nxt;
            serial_data_in <= sin_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    p4_sout_cmos_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE2
        clk_en && p4_func[BIT_SOUT] && p4_con0_r[2] && p4_con1_r[2] && !p4_dir_r[2]
        |=> port4_pin_oe[2] && port4_pin_out[2] == $past(serial_data_out))
        else $error("port 4 data out not driven");
    pa_sck_cmos_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE8
        clk_en && pa_func[BIT_SCK] && serial_clock_oe && pa_con0_r[1] && pa_con1_r[1]
        && !pa_dir_r[1] |=> porta_pin_oe[1] && porta_pin_out[1] == $past(serial_clock_out))
        else $error("port A clock not driven");
    p4_in_pins_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE3
        clk_en && p4_dir_r[1] && p4_dir_r[0] |=> !port4_pin_oe[1] && !port4_pin_oe[0])
        else $error("port 4 input pin driven");
    pa_sin_path_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE9
        clk_en && pa_func[BIT_SIN] && pa_dir_r[0] && !(p4_func[0] && p4_dir_r[0])
        |=> serial_data_in == $past(porta_pin_in[0]))
        else $error("port A data in lost");
    p4_sel_need_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE1
        clk_en && p4_sel1_r[BIT_SIN] && !(pa_func[BIT_SIN] && pa_dir_r[BIT_SIN])
        |=> !serial_data_in)
        else $error("port 4 data in routed without selection");
    p4_sin_all_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE1
        clk_en && p4_all && p4_dir_r[BIT_SIN]
        |=> serial_data_in == $past(port4_pin_in[BIT_SIN]))
        else $error("port 4 data in not routed");
    p4_sck_rel_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE6
        clk_en && p4_func[BIT_SCK] && !serial_clock_oe |=> !port4_pin_oe[BIT_SCK])
        else $error("port 4 clock pin driven in slave mode");
    p4_sck_in_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE3
        clk_en && p4_func[BIT_SCK] && p4_dir_r[BIT_SCK]
        |=> serial_clock_in == $past(port4_pin_in[BIT_SCK]))
        else $error("port 4 clock input lost");
    freeze_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        !clk_en |=> $stable(port4_pin_out) && $stable(porta_pin_out) && $stable(reg_rdata)
        && $stable(serial_data_in) && $stable(serial_clock_in))
        else $error("outputs moved while clock enable low");
    rdata_idle_a: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not cleared");
    p4_data_ign_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE5
        clk_en && p4_func[2] && $stable(serial_data_out) && $changed(p4_dat_r)
        |=> $stable(port4_pin_out[2]) || $changed(p4_con0_r) || $changed(p4_con1_r))
        else $error("port 4 data register leaked");
    pa_data_ign_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE11
        clk_en && pa_all && !pa_dir_r[2] && pa_con0_r[2] && pa_con1_r[2]
        |=> porta_pin_out[2] == $past(serial_data_out))
        else $error("port A data register leaked");
    pa_sck_in_a: assert property (@(posedge core_clk) disable iff (reset) // see RULE13
        clk_en && pa_func[1] && pa_dir_r[1] && !(p4_func[1] && p4_dir_r[1])
        |=> serial_clock_in == $past(porta_pin_in[1]) && !porta_pin_oe[1])
        else $error("port A clock input wrong");
endmodule : sspr_top

// >>> rtl/sspr_pkg.sv
// Constants for the sync serial pin routing block.
// Operation
// RULE1: Port 4 pins 2..0 go to the serial channel when select-high bits are 0 and select-low bits are 1.
// RULE2: Port 4 bit 2 drives push-pull when both drive bits are 1 and direction is 0, carrying serial data out.
// RULE3: In slave mode port 4 bits 1 and 0 are inputs when their direction bits are 1.
// RULE4: Software picks the input mode of port 4 bits 1 and 0 freely with their drive bits.
// RULE5: While port 4 bits 2..0 serve the channel, their data register bits do not affect the pins.
// RULE6: Port 4 carries data out on bit 2, clock on bit 1, data in on bit 0, selected as in master mode.
// RULE7: Port A pins 2..0 go to the serial channel when the port A select bits hold 1.
// RULE8: In master mode port A bits 2 and 1 drive push-pull when both drive bits are 1 and direction is 0.
// RULE9: In master mode port A bit 0 is an input carrying serial data in when its direction bit is 1.
// RULE10: Software picks the input state of port A bit 0 freely with its drive bits.
// RULE11: While port A bits 2..0 serve the channel, their data register bits do not affect the pins.
// RULE12: Slave mode on port A uses the same selection as master mode.
// RULE13: In slave mode port A bit 1 is a clock input when its direction bit is 1.
package sspr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PIN_W = 8;
    localparam logic [15:0] P4_DATA_ADDR = 16'hF220;
    localparam logic [15:0] P4_DIR_ADDR = 16'hF221;
    localparam logic [15:0] P4_CON0_ADDR = 16'hF222;
    localparam logic [15:0] P4_CON1_ADDR = 16'hF223;
    localparam logic [15:0] P4_SEL0_ADDR = 16'hF224;
    localparam logic [15:0] P4_SEL1_ADDR = 16'hF225;
    localparam logic [15:0] PA_DATA_ADDR = 16'hF250;
    localparam logic [15:0] PA_DIR_ADDR = 16'hF251;
    localparam logic [15:0] PA_CON0_ADDR = 16'hF252;
    localparam logic [15:0] PA_CON1_ADDR = 16'hF253;
    localparam logic [15:0] PA_SEL0_ADDR = 16'hF254;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] P4_SEL_MASK = 8'h07;
    localparam logic [7:0] PA_SEL_MASK = 8'h0F;
    localparam int BIT_SOUT = 2;
    localparam int BIT_SCK = 1;
    localparam int BIT_SIN = 0;
    typedef enum logic [1:0] {
        SSPR_PIN_IN = 2'b00,
        SSPR_PIN_CMOS = 2'b11,
        SSPR_PIN_NCH = 2'b01,
        SSPR_PIN_PCH = 2'b10
    } sspr_drive_e;
endpackage : sspr_pkg

// >>> rtl/sspr_port_if.sv
// Interface carrying one port's configuration and pin signals between modules.
`timescale 1ns/10ps
interface sspr_port_if;
    logic [7:0] dat;
    logic [7:0] dir;
    logic [7:0] con0;
    logic [7:0] con1;
    logic [2:0] func_en;
    logic [2:0] alt_out;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    modport ctrl (output dat, dir, con0, con1, func_en, alt_out, input pin_out, pin_oe);
    modport pad (input dat, dir, con0, con1, func_en, alt_out, output pin_out, pin_oe);
endinterface : sspr_port_if

// >>> rtl/sspr_pad_ctl.sv
// Combinational pad control for one 8-bit port with three serial alternate bits.
`timescale 1ns/10ps
module sspr_pad_ctl (
    sspr_port_if.pad port
);
    import sspr_pkg::*;

    // Drive value and enable per bit; direction 1 means input.
    function automatic logic [1:0] pad_drive(input logic d, input logic dir, input logic c0,
                                             input logic c1);
        logic en;
        logic val;
        en = !dir && (c0 || c1);
        case ({c1, c0})
            2'b01: val = 1'b0;
            2'b10: val = 1'b1;
            default: val = d;
        endcase
        if ({c1, c0} == 2'b01 && d) begin
            en = 1'b0;
        end
        if ({c1, c0} == 2'b10 && !d) begin
            en = 1'b0;
        end
        return {en, val};
    endfunction : pad_drive

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            wire src;
            wire [1:0] drv;
            if (i < 3) begin : g_alt
                assign src = port.func_en[i] ? port.alt_out[i] : port.dat[i]; // see RULE5 RULE11
            end else begin : g_gpio
                assign src = port.dat[i];
            end
            assign drv = pad_drive(src, port.dir[i], port.con0[i], port.con1[i]); // see RULE2 RULE8
            assign port.pin_out[i] = drv[0];
            assign port.pin_oe[i] = drv[1];
        end
    endgenerate
endmodule : sspr_pad_ctl

// >>> bench/sspr_peer.sv
// Model of the far side of one port: resolves each wire from device and peer drivers.
`timescale 1ns/10ps
module sspr_peer (
    // Device side.
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Peer side.
    input wire logic [7:0] peer_val,
    output logic [7:0] pin_in
);
    // A bit the device drives shows its level; every other bit carries the peer's level.
    assign pin_in = (pin_out & pin_oe) | (peer_val & ~pin_oe);
endmodule : sspr_peer

// >>> bench/test_sspr_top.sv
// Self-checking testbench of the sync serial pin routing block.
`timescale 1ns/10ps
module test_sspr_top;
    import sspr_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_rdata;
    logic serial_data_out = 1'b0;
    logic serial_clock_out = 1'b0;
    logic serial_clock_oe = 1'b0;
    logic serial_clock_in, serial_data_in;
    logic [7:0] p4_in, p4_out, p4_oe, pa_in, pa_out, pa_oe;
    logic [7:0] peer_val = 8'h00;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #5 core_clk = ~core_clk;
    sspr_top uut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_data_out(serial_data_out), .serial_clock_out(serial_clock_out),
        .serial_clock_oe(serial_clock_oe), .serial_clock_in(serial_clock_in),
        .serial_data_in(serial_data_in), .port4_pin_in(p4_in), .port4_pin_out(p4_out),
        .port4_pin_oe(p4_oe), .porta_pin_in(pa_in), .porta_pin_out(pa_out),
        .porta_pin_oe(pa_oe));
    sspr_peer peer4 (.pin_out(p4_out), .pin_oe(p4_oe), .peer_val(peer_val), .pin_in(p4_in));
    sspr_peer peera (.pin_out(pa_out), .pin_oe(pa_oe), .peer_val(peer_val), .pin_in(pa_in));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata, exp);
    endtask : rd
    // Drives both serial lines and the peer through all four level pairs; input pins step through all four drive codes, data out stays push-pull.
    task automatic route(input logic [15:0] b, input logic slv);
        logic [7:0] po, oe;
        logic [1:0] m;
        wr(b, 8'hFF);
        wr(b + 16'h0001, slv ? 8'h03 : 8'h01);
        serial_clock_oe <= !slv;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(b + 16'h0002, {5'h00, 1'b1, slv ? m[0] : 1'b1, m[0]});
            wr(b + 16'h0003, {5'h00, 1'b1, slv ? m[1] : 1'b1, m[1]});
            serial_data_out <= m[0];
            serial_clock_out <= m[1];
            peer_val <= {m, 4'h0, m[0], ~m[1]};
            repeat (3) @(posedge core_clk);
            #1;
            po = b[4] ? pa_out : p4_out;
            oe = b[4] ? pa_oe : p4_oe;
            chk("oe", oe & 8'h07, slv ? 8'h04 : 8'h06);
            chk("out", po & oe & 8'h06, {5'h00, m[0], m[1] & !slv, 1'b0});
            chk("sin", {7'h00, serial_data_in}, {7'h00, ~m[1]});
            if (slv) begin
                chk("sck", {7'h00, serial_clock_in}, {7'h00, m[0]});
            end
        end
    endtask : route
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk("p4oe", p4_oe, 8'h00);
        chk("paoe", pa_oe, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd(16'hF220 + i[15:0], REG_RESET);
        end
        for (int i = 0; i < 5; i++) begin
            rd(16'hF250 + i[15:0], REG_RESET);
        end
        for (int i = 0; i < 4; i++) begin
            wr(16'hF220 + i[15:0], 8'hA5 ^ i[7:0]);
            wr(16'hF250 + i[15:0], 8'h5A ^ i[7:0]);
            rd(16'hF220 + i[15:0], 8'hA5 ^ i[7:0]);
            rd(16'hF250 + i[15:0], 8'h5A ^ i[7:0]);
        end
        wr(P4_SEL0_ADDR, 8'hFF);
        wr(P4_SEL1_ADDR, 8'hFF);
        wr(PA_SEL0_ADDR, 8'hFF);
        wr(16'hF226, 8'hFF);
        rd(P4_SEL0_ADDR, P4_SEL_MASK);
        rd(P4_SEL1_ADDR, P4_SEL_MASK);
        rd(PA_SEL0_ADDR, PA_SEL_MASK);
        rd(16'hF226, 8'h00);
        wr(PA_SEL0_ADDR, 8'h00);
        wr(P4_SEL1_ADDR, 8'h00);
        wr(P4_SEL0_ADDR, 8'h07);
        route(P4_DATA_ADDR, 1'b0);
        route(P4_DATA_ADDR, 1'b1);
        // A set select-high bit takes the data-in pin away from the channel.
        peer_val <= 8'h01;
        wr(P4_SEL1_ADDR, 8'h01);
        repeat (3) @(posedge core_clk);
        #1;
        chk("unrouted_sin", {7'h00, serial_data_in}, 8'h00);
        wr(P4_SEL1_ADDR, 8'h00);
        wr(P4_SEL0_ADDR, 8'h00);
        wr(PA_SEL0_ADDR, 8'h07);
        route(PA_DATA_ADDR, 1'b0);
        route(PA_DATA_ADDR, 1'b1);
        // Clock enable low holds the port A data-out pin; afterwards the pin follows the unit again.
        clk_en <= 1'b0;
        serial_data_out <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk("frozen", pa_out & 8'h04, 8'h04);
        clk_en <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("resumed", pa_out & 8'h04, 8'h00);
        end_sim();
    end
endmodule : test_sspr_top
